// File: rtc_alarm_a.sv
// year register and first alarm behind a two-wire serial register port
// assumes scl/sda inputs are already synchronous to core_clk and tick_1hz
// pulses one cycle after each timekeeping update with time inputs settled
//
// How it works
// [RULE1] year register holds bcd tens in 7:4, units in 3:0, read and write
// [RULE2] host programs the alarm by writing registers 0dh through 12h
// [RULE3] interrupt pin fires on a match only when the enable bit at 01h is set
// [RULE4] bit 7 of the seconds through day/date alarm registers, and month bits 7 and 6, are masks
// [RULE5] with all masks clear every timekeeping field must equal its alarm field
// [RULE6] all six masks set gives an alarm every second, select ignored
// [RULE7] clearing seconds, then minutes, then hours masks adds those fields
// [RULE8] select bit 0 compares date of month, 1 compares day of week
// [RULE9] year mask set, others clear, date selected: month, date and time match
// [RULE10] all masks clear with date selected: full year through seconds match
// [RULE11] other mask combinations are the host's fault and give undefined alarms
// [RULE12] low six bits of day/date alarm are read as day or date per select
// [RULE13] alarm seconds: mask bit 7, tens 6:4, units 3:0
// [RULE14] alarm minutes: mask bit 7, tens 6:4, units 3:0
// [RULE15] alarm hours: mask bit 7, bit 6 unused, tens 5:4, units 3:0
// [RULE16] alarm day/date: mask bit 7, select bit 6, tens 5:4, units 3:0
// [RULE17] alarm month: month mask 7, year mask 6, tens 4, units 3:0
// [RULE18] alarm year held separately, tens 7:4, units 3:0
// [RULE19] compare once per second update, one event per qualifying second
// [RULE20] year and all alarm fields reset to zero
`timescale 1ns/1ps
module rtc_alarm_a #(
  parameter logic [6:0] dev_addr = 7'h5a // arbitrary
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic tick_1hz,
  input wire logic [6:0] time_sec,
  input wire logic [6:0] time_min,
  input wire logic [5:0] time_hour,
  input wire logic [2:0] time_day,
  input wire logic [5:0] time_date,
  input wire logic [4:0] time_month,
  output logic int_n,
  output logic alarm_hit
);

  if (dev_addr[6:3] == 4'h0 || dev_addr[6:3] == 4'hf) begin : g_bad_addr
    $error("device address falls in a reserved group");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  rtc_alarm_pkg::i2c_state_t state_q, nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] rd_sh_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic scl_q;
  logic sda_q;
  logic sda_oe_q;
  logic irq_en_q;
  logic [7:0] year_q;
  logic [7:0] a_sec_q;
  logic [7:0] a_min_q;
  logic [7:0] a_hour_q;
  logic [7:0] a_dd_q;
  logic [7:0] a_mon_q;
  logic [7:0] a_yr_q;
  logic hit_q;
  logic int_n_q;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  logic byte_done;
  logic wr_en;
  logic [7:0] rd_now;

  alarm_if aif();

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  function automatic logic [7:0] rd_byte(input logic [7:0] addr);
    case (addr)
      rtc_alarm_pkg::irq_en_addr: rd_byte = {7'h00, irq_en_q};
      rtc_alarm_pkg::year_addr: rd_byte = year_q;
      rtc_alarm_pkg::a_sec_addr: rd_byte = a_sec_q;
      rtc_alarm_pkg::a_min_addr: rd_byte = a_min_q;
      rtc_alarm_pkg::a_hour_addr: rd_byte = a_hour_q;
      rtc_alarm_pkg::a_dd_addr: rd_byte = a_dd_q;
      rtc_alarm_pkg::a_mon_addr: rd_byte = a_mon_q;
      rtc_alarm_pkg::a_yr_addr: rd_byte = a_yr_q;
      default: rd_byte = rtc_alarm_pkg::unmapped_data;
    endcase
  endfunction

  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign start_c = scl_q & scl_in & sda_q & ~sda_in;
  assign stop_c = scl_q & scl_in & ~sda_q & sda_in;
  assign scl_rise = ~scl_q & scl_in;
  assign scl_fall = scl_q & ~scl_in;
  assign byte_done = scl_fall && cnt_q == rtc_alarm_pkg::bits_per_byte;
  assign wr_en = state_q == rtc_alarm_pkg::st_wr && byte_done && !start_c && !stop_c;
  always_comb rd_now = rd_byte(ptr_q);

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= rtc_alarm_pkg::st_idle;
      nxt_q <= rtc_alarm_pkg::st_idle;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rd_sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= rtc_alarm_pkg::st_idle;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      state_q <= rtc_alarm_pkg::st_addr;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        rtc_alarm_pkg::st_idle: begin
          sda_oe_q <= 1'b0;
        end
        rtc_alarm_pkg::st_addr, rtc_alarm_pkg::st_ptr, rtc_alarm_pkg::st_wr: begin
          if (scl_rise && cnt_q != rtc_alarm_pkg::bits_per_byte) begin
            shift_q <= {shift_q[6:0], sda_in};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            if (state_q == rtc_alarm_pkg::st_addr && shift_q[7:1] != dev_addr) begin
              state_q <= rtc_alarm_pkg::st_idle;
            end else begin
              sda_oe_q <= 1'b1;
              state_q <= rtc_alarm_pkg::st_ack;
              if (state_q == rtc_alarm_pkg::st_addr) begin
                rw_q <= shift_q[0];
                nxt_q <= shift_q[0] ? rtc_alarm_pkg::st_rd : rtc_alarm_pkg::st_ptr;
              end else if (state_q == rtc_alarm_pkg::st_ptr) begin
                ptr_q <= shift_q;
                nxt_q <= rtc_alarm_pkg::st_wr;
              end else begin
                ptr_q <= ptr_q + 8'h01;
                nxt_q <= rtc_alarm_pkg::st_wr;
              end
            end
          end
        end
        rtc_alarm_pkg::st_ack: begin
          if (scl_fall) begin
            state_q <= nxt_q;
            if (nxt_q == rtc_alarm_pkg::st_rd) begin
              rd_sh_q <= rd_now;
              sda_oe_q <= ~rd_now[7];
              cnt_q <= 4'h1;
            end else begin
              sda_oe_q <= 1'b0;
            end
          end
        end
        rtc_alarm_pkg::st_rd: begin
          if (byte_done) begin
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
            ptr_q <= ptr_q + 8'h01;
            state_q <= rtc_alarm_pkg::st_rd_ack;
          end else if (scl_fall) begin
            sda_oe_q <= ~rd_sh_q[6];
            rd_sh_q <= {rd_sh_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        rtc_alarm_pkg::st_rd_ack: begin
          if (scl_rise) begin
            shift_q <= {7'h00, sda_in};
          end else if (scl_fall) begin
            if (shift_q[0]) begin
              state_q <= rtc_alarm_pkg::st_idle;
            end else begin
              rd_sh_q <= rd_now;
              sda_oe_q <= ~rd_now[7];
              cnt_q <= 4'h1;
              state_q <= rtc_alarm_pkg::st_rd;
            end
          end
        end
        default: begin
          state_q <= rtc_alarm_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  assign sda_oe = sda_oe_q;

  // ----------------------------------------
  // control and year registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_en_q <= 1'b0;
      year_q <= rtc_alarm_pkg::reg_reset; // RULE20
    end else if (wr_en) begin
      if (ptr_q == rtc_alarm_pkg::irq_en_addr) begin
        irq_en_q <= shift_q[rtc_alarm_pkg::irq_en_bit];
      end
      if (ptr_q == rtc_alarm_pkg::year_addr) begin
        year_q <= shift_q & rtc_alarm_pkg::full_wmask; // RULE1
      end
    end
  end

  // ----------------------------------------
  // first-alarm registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      a_sec_q <= rtc_alarm_pkg::reg_reset; // RULE20
      a_min_q <= rtc_alarm_pkg::reg_reset;
      a_hour_q <= rtc_alarm_pkg::reg_reset;
      a_dd_q <= rtc_alarm_pkg::reg_reset;
      a_mon_q <= rtc_alarm_pkg::reg_reset;
      a_yr_q <= rtc_alarm_pkg::reg_reset;
    end else if (wr_en) begin
      case (ptr_q)
        rtc_alarm_pkg::a_sec_addr: a_sec_q <= shift_q & rtc_alarm_pkg::full_wmask; // RULE13
        rtc_alarm_pkg::a_min_addr: a_min_q <= shift_q & rtc_alarm_pkg::full_wmask; // RULE14
        rtc_alarm_pkg::a_hour_addr: a_hour_q <= shift_q & rtc_alarm_pkg::hour_wmask; // RULE15
        rtc_alarm_pkg::a_dd_addr: a_dd_q <= shift_q & rtc_alarm_pkg::full_wmask; // RULE16
        rtc_alarm_pkg::a_mon_addr: a_mon_q <= shift_q & rtc_alarm_pkg::mon_wmask; // RULE17
        rtc_alarm_pkg::a_yr_addr: a_yr_q <= shift_q & rtc_alarm_pkg::full_wmask; // RULE18
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // comparator
  // ----------------------------------------
  assign aif.a_sec = a_sec_q;
  assign aif.a_min = a_min_q;
  assign aif.a_hour = a_hour_q;
  assign aif.a_dd = a_dd_q;
  assign aif.a_mon = a_mon_q;
  assign aif.a_yr = a_yr_q;
  assign aif.year = year_q;
  assign aif.cur_sec = time_sec;
  assign aif.cur_min = time_min;
  assign aif.cur_hour = time_hour;
  assign aif.cur_day = time_day;
  assign aif.cur_date = time_date;
  assign aif.cur_mon = time_month;

  alarm_a_match u_match (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .bus(aif.cmp)
  );

  // ----------------------------------------
  // alarm event and interrupt pin
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_q <= 1'b0;
      int_n_q <= 1'b1;
    end else begin
      hit_q <= tick_1hz & aif.match; // RULE19
      int_n_q <= ~(tick_1hz & aif.match & irq_en_q); // RULE3
    end
  end

  assign alarm_hit = hit_q;
  assign int_n = int_n_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  hit_cause_a: assert property (alarm_hit |-> $past(tick_1hz) && $past(aif.match)) // RULE19
    else $error("alarm event without a matching update");
  hit_follow_a: assert property (tick_1hz && aif.match |=> alarm_hit) // RULE19
    else $error("matching update gave no event");
  irq_gate_a: assert property (!int_n |-> alarm_hit && $past(irq_en_q)) // RULE3
    else $error("interrupt without enable or match");
  irq_fire_a: assert property (alarm_hit && $past(irq_en_q) |-> !int_n) // RULE3
    else $error("enabled match left interrupt high");
  hour_spare_a: assert property (a_hour_q[6] == 1'b0) // RULE15
    else $error("unused hours bit set");
  month_spare_a: assert property (a_mon_q[5] == 1'b0) // RULE17
    else $error("reserved month bit set");
  year_write_a: assert property (wr_en && ptr_q == rtc_alarm_pkg::year_addr |=> year_q == $past(shift_q)) // RULE1
    else $error("year write lost");
  alarm_write_a: assert property (wr_en && ptr_q == rtc_alarm_pkg::a_yr_addr |=> a_yr_q == $past(shift_q)) // RULE18
    else $error("alarm year write lost");
  ack_drive_a: assert property (state_q == rtc_alarm_pkg::st_ack |-> sda_oe) // RULE2
    else $error("no acknowledge driven");
  irq_quiet_a: assert property (!irq_en_q |=> int_n) // RULE3
    else $error("interrupt while disabled");
  ptr_step_a: assert property (wr_en |=> ptr_q == $past(ptr_q) + 8'h01) // RULE2
    else $error("pointer did not advance after a write");
  year_keep_a: assert property (!(wr_en && ptr_q == rtc_alarm_pkg::year_addr) |=> $stable(year_q)) // RULE1
    else $error("year changed without a write");
  rd_release_a: assert property (state_q == rtc_alarm_pkg::st_rd_ack |-> !sda_oe) // RULE2
    else $error("data line held during host acknowledge");
  rd_dir_a: assert property (state_q == rtc_alarm_pkg::st_rd |-> rw_q) // RULE2
    else $error("read data sent without a read address");

  irq_seen_c: cover property (!int_n);
  alarm_hit_c: cover property (alarm_hit);
  burst_end_c: cover property (wr_en && ptr_q == rtc_alarm_pkg::a_yr_addr);
  year_wr_c: cover property (wr_en && ptr_q == rtc_alarm_pkg::year_addr);
  read_c: cover property (state_q == rtc_alarm_pkg::st_rd_ack);

endmodule

// File: rtc_alarm_pkg.sv
// constants, field layouts and types shared by the year and first-alarm block
// assumes nothing beyond a SystemVerilog compiler
package rtc_alarm_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] irq_en_addr = 8'h01;
  localparam logic [7:0] year_addr = 8'h0c;
  localparam logic [7:0] a_sec_addr = 8'h0d;
  localparam logic [7:0] a_min_addr = 8'h0e;
  localparam logic [7:0] a_hour_addr = 8'h0f;
  localparam logic [7:0] a_dd_addr = 8'h10;
  localparam logic [7:0] a_mon_addr = 8'h11;
  localparam logic [7:0] a_yr_addr = 8'h12;

  // ----------------------------------------
  // reset values and writable bits
  // ----------------------------------------
  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [7:0] full_wmask = 8'hff;
  localparam logic [7:0] hour_wmask = 8'hbf;
  localparam logic [7:0] mon_wmask = 8'hdf;
  localparam logic [7:0] unmapped_data = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int mask_bit = 7;
  localparam int yr_mask_bit = 6;
  localparam int sel_bit = 6;
  localparam int irq_en_bit = 0;

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  localparam logic [3:0] bits_per_byte = 4'h8;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_ptr,
    st_wr,
    st_ack,
    st_rd,
    st_rd_ack
  } i2c_state_t;

  // one field: masked, or stored value equals running value
  function automatic logic field_ok(input logic m, input logic [6:0] a, input logic [6:0] b);
    return m | (a == b);
  endfunction

endpackage

// File: alarm_if.sv
// bundle between the register file and the first-alarm comparator
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface alarm_if;
  logic [7:0] a_sec;
  logic [7:0] a_min;
  logic [7:0] a_hour;
  logic [7:0] a_dd;
  logic [7:0] a_mon;
  logic [7:0] a_yr;
  logic [7:0] year;
  logic [6:0] cur_sec;
  logic [6:0] cur_min;
  logic [5:0] cur_hour;
  logic [2:0] cur_day;
  logic [5:0] cur_date;
  logic [4:0] cur_mon;
  logic match;

  modport regs(
    output a_sec, a_min, a_hour, a_dd, a_mon, a_yr, year,
    output cur_sec, cur_min, cur_hour, cur_day, cur_date, cur_mon,
    input match
  );
  modport cmp(
    input a_sec, a_min, a_hour, a_dd, a_mon, a_yr, year,
    input cur_sec, cur_min, cur_hour, cur_day, cur_date, cur_mon,
    output match
  );
endinterface

// File: alarm_a_match.sv
// first-alarm comparator: masked field compare of stored alarm against running time
// assumes current time and alarm values are stable in the cycle they are sampled
`timescale 1ns/1ps
module alarm_a_match (
  input wire logic core_clk,
  input wire logic reset_n,
  alarm_if.cmp bus
);

  logic sec_ok, min_ok, hour_ok, dd_ok, mon_ok, yr_ok;
  logic [6:0] dd_cur;
  logic sel;

  // ----------------------------------------
  // field compare
  // ----------------------------------------
  always_comb begin
    sel = bus.a_dd[rtc_alarm_pkg::sel_bit];
    dd_cur = sel ? {4'h0, bus.cur_day} : {1'b0, bus.cur_date}; // RULE8 RULE12
    sec_ok = rtc_alarm_pkg::field_ok(bus.a_sec[rtc_alarm_pkg::mask_bit], bus.a_sec[6:0], bus.cur_sec); // RULE4 RULE13
    min_ok = rtc_alarm_pkg::field_ok(bus.a_min[rtc_alarm_pkg::mask_bit], bus.a_min[6:0], bus.cur_min); // RULE14
    hour_ok = rtc_alarm_pkg::field_ok(bus.a_hour[rtc_alarm_pkg::mask_bit], {1'b0, bus.a_hour[5:0]},
                                      {1'b0, bus.cur_hour}); // RULE15
    dd_ok = rtc_alarm_pkg::field_ok(bus.a_dd[rtc_alarm_pkg::mask_bit], {1'b0, bus.a_dd[5:0]}, dd_cur); // RULE16
    mon_ok = rtc_alarm_pkg::field_ok(bus.a_mon[rtc_alarm_pkg::mask_bit], {2'h0, bus.a_mon[4:0]},
                                     {2'h0, bus.cur_mon}); // RULE17
    yr_ok = bus.a_mon[rtc_alarm_pkg::yr_mask_bit] | (bus.a_yr == bus.year); // RULE18
  end

  assign bus.match = sec_ok & min_ok & hour_ok & dd_ok & mon_ok & yr_ok; // RULE5 RULE7 RULE9 RULE10

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [5:0] masks;
  assign masks = {bus.a_mon[7:6], bus.a_dd[7], bus.a_hour[7], bus.a_min[7], bus.a_sec[7]};

  all_masked_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE6
    masks == 6'h3f |-> bus.match) else $error("all masks set but no match");
  sec_only_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE7
    masks == 6'h3e |-> bus.match == (bus.a_sec[6:0] == bus.cur_sec)) else $error("seconds match wrong");
  day_select_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE8
    masks == 6'h30 && bus.a_dd[6] && bus.a_dd[5:0] != {3'h0, bus.cur_day} |-> !bus.match)
    else $error("day select ignored");
  full_match_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE10
    masks == 6'h00 && !bus.a_dd[6] |-> bus.match == (bus.a_yr == bus.year && bus.a_mon[4:0] == bus.cur_mon
      && bus.a_dd[5:0] == bus.cur_date && bus.a_hour[5:0] == bus.cur_hour && bus.a_min[6:0] == bus.cur_min
      && bus.a_sec[6:0] == bus.cur_sec)) else $error("full match wrong");
  month_match_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE9
    masks == 6'h10 && !bus.a_dd[6] && bus.a_mon[4:0] != bus.cur_mon |-> !bus.match)
    else $error("month ignored");

endmodule

// File: i2c_host_model.sv
// two-wire host model: start, stop, burst writes and single-byte reads
// assumes the bench resolves the pulled-up data line from both drivers
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] dev_addr = 7'h5a
) (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ----------------
  // bus phases
  // ----------------
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic start_cond();
    cyc(1);
    sda_pull <= 1'b0;
    cyc(2);
    scl <= 1'b1;
    cyc(4);
    sda_pull <= 1'b1;
    cyc(4);
    scl <= 1'b0;
  endtask
  task automatic stop_cond();
    cyc(1);
    sda_pull <= 1'b1;
    cyc(2);
    scl <= 1'b1;
    cyc(4);
    sda_pull <= 1'b0;
    cyc(4);
  endtask
  task automatic put_bit(input logic b);
    cyc(1);
    sda_pull <= ~b;
    cyc(2);
    scl <= 1'b1;
    cyc(4);
    scl <= 1'b0;
  endtask
  task automatic get_bit(output logic b);
    cyc(1);
    sda_pull <= 1'b0;
    cyc(2);
    scl <= 1'b1;
    cyc(2);
    #1 b = sda_line;
    cyc(2);
    scl <= 1'b0;
  endtask
  // ----------------
  // transfers
  // ----------------
  task automatic send_byte(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    ok = ok & ~a;
  endtask
  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d [7], input int n, output logic ok);
    ok = 1'b1;
    start_cond();
    send_byte({dev_addr, 1'b0}, ok);
    send_byte(ptr, ok);
    for (int i = 0; i < n; i++) begin
      send_byte(d[i], ok);
    end
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start_cond();
    send_byte({dev_addr, 1'b0}, ok);
    send_byte(ptr, ok);
    start_cond();
    send_byte({dev_addr, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    stop_cond();
  endtask
endmodule

// File: rtc_year_and_alarm_one_match_test.sv
// self-checking bench for the year register and first alarm
// assumes the design package, interface, modules and host model are compiled first
`timescale 1ns/1ps
module rtc_year_and_alarm_one_match_test;
  localparam logic [5:0] cmask [8] = '{6'h3f, 6'h3e, 6'h3c, 6'h38, 6'h30, 6'h20, 6'h00, 6'h30};
  logic core_clk;
  logic reset_n;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  wire logic sda_line = ~sda_pull & ~(sda_oe & ~sda_out);
  logic tick_1hz;
  logic [6:0] time_sec;
  logic [6:0] time_min;
  logic [5:0] time_hour;
  logic [2:0] time_day;
  logic [5:0] time_date;
  logic [4:0] time_month;
  logic int_n;
  logic alarm_hit;
  logic [7:0] alm [6];
  logic [7:0] yr;
  logic en;
  logic [7:0] wbuf [7];
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 62;

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  i2c_host_model host_u (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  rtc_alarm_a dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .tick_1hz(tick_1hz), .time_sec(time_sec),
    .time_min(time_min), .time_hour(time_hour), .time_day(time_day), .time_date(time_date),
    .time_month(time_month), .int_n(int_n), .alarm_hit(alarm_hit)
  );

  // ----------------
  // checking and reference
  // ----------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask
  function automatic logic model_hit();
    logic [5:0] dd;
    dd = alm[3][6] ? {3'h0, time_day} : time_date;
    return (alm[0][7] | (alm[0][6:0] == time_sec)) & (alm[1][7] | (alm[1][6:0] == time_min))
      & (alm[2][7] | (alm[2][5:0] == time_hour)) & (alm[3][7] | (alm[3][5:0] == dd))
      & (alm[4][7] | (alm[4][4:0] == time_month)) & (alm[4][6] | (alm[5] == yr));
  endfunction
  task automatic rd_cmp(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] got;
    logic ok;
    host_u.read_reg(ptr, got, ok);
    cmp_byte(got, exp);
  endtask
  task automatic wr1(input logic [7:0] ptr, input logic [7:0] v);
    logic ok;
    wbuf[0] = v;
    host_u.write_regs(ptr, wbuf, 1, ok);
  endtask
  task automatic do_tick();
    logic e;
    @(posedge core_clk);
    tick_1hz <= 1'b1;
    #1 e = model_hit();
    @(posedge core_clk);
    tick_1hz <= 1'b0;
    #1 cmp_bit(alarm_hit, e);
    cmp_bit(int_n, ~(e & en));
    @(posedge core_clk);
    #1 cmp_bit(alarm_hit, 1'b0);
    cmp_bit(int_n, 1'b1);
  endtask

  // ----------------
  // main sequence
  // ----------------
  initial begin
    logic [7:0] d;
    logic ok;
    logic [5:0] cm;
    logic sel;
    logic [6:0] vs;
    logic [6:0] vm;
    logic [5:0] vh;
    logic [2:0] vd;
    logic [5:0] vt;
    logic [4:0] vo;
    reset_n = 1'b0;
    tick_1hz = 1'b0;
    time_sec = 7'h00;
    time_min = 7'h00;
    time_hour = 6'h00;
    time_day = 3'h0;
    time_date = 6'h00;
    time_month = 5'h00;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_cmp(8'h0c + 8'(i), 8'h00);
    end
    rd_cmp(8'h01, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 7; i++) begin
      wbuf[i] = 8'($random(seed));
    end
    host_u.write_regs(rtc_alarm_pkg::year_addr, wbuf, 7, ok);
    cmp_bit(ok, 1'b1);
    for (int i = 0; i < 7; i++) begin
      d = (i == 3) ? rtc_alarm_pkg::hour_wmask : (i == 5) ? rtc_alarm_pkg::mon_wmask : 8'hff;
      rd_cmp(8'h0c + 8'(i), wbuf[i] & d);
    end
    wr1(8'h30, 8'ha5);
    rd_cmp(8'h30, rtc_alarm_pkg::unmapped_data);
    wr1(8'h01, 8'hff);
    rd_cmp(8'h01, 8'h01);
    $display("test register_access done");
    for (int c = 0; c < 8; c++) begin
      for (int it = 0; it < 4; it++) begin
        cm = cmask[c];
        sel = (c < 4) ? 1'($random(seed)) : (c == 7);
        en = 1'($random(seed));
        vs = 7'($random(seed));
        vm = 7'($random(seed));
        vh = 6'($random(seed));
        vd = 3'($random(seed));
        vt = 6'($random(seed));
        vo = 5'($random(seed));
        yr = 8'($random(seed));
        wr1(8'h01, {7'h00, en});
        alm[0] = {cm[0], vs};
        alm[1] = {cm[1], vm};
        alm[2] = {cm[2], 1'b0, vh};
        alm[3] = {cm[3], sel, sel ? {3'h0, vd} : vt};
        alm[4] = {cm[4], cm[5], 1'b0, vo};
        alm[5] = yr ^ 8'(it == 3);
        wbuf[0] = yr;
        for (int i = 0; i < 6; i++) begin
          wbuf[i + 1] = alm[i];
        end
        host_u.write_regs(8'h0c, wbuf, 7, ok);
        for (int p = 0; p < 7; p++) begin
          @(posedge core_clk);
          time_sec <= vs ^ 7'(p == 1);
          time_min <= vm ^ 7'(p == 2);
          time_hour <= vh ^ 6'(p == 3);
          time_date <= vt ^ 6'(p == 4);
          time_day <= vd ^ 3'(p == 5);
          time_month <= vo ^ 5'(p == 6);
          do_tick();
        end
      end
      $display("test alarm_combo %0d done", c);
    end
    end_sim();
  end
endmodule
